// ---- shared/sftr_pkg.sv ----
// package for the synthesizer trim register bank
// assumes a byte-wide register port with 7-bit in-page address and a page bit
package sftr_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses inside page 0)
  // ---------------------------------------------------------------
  localparam logic [7:0] SFTR_ADDR_TRIM_B0 = 8'h73;
  localparam logic [7:0] SFTR_ADDR_TRIM_B3 = 8'h76;
  localparam logic [7:0] SFTR_ADDR_FILTER = 8'h77;
  localparam logic [7:0] SFTR_ADDR_PHASE0 = 8'h78;
  localparam logic [7:0] SFTR_ADDR_PAGE = 8'h7f;
  // ---------------------------------------------------------------
  // reset values and fields
  // ---------------------------------------------------------------
  localparam logic [31:0] SFTR_TRIM_RESET = 32'h046aaaab;
  localparam logic [7:0] SFTR_FILTER_RESET = 8'h00;
  localparam logic [7:0] SFTR_PHASE_RESET = 8'h00;
  localparam logic [7:0] SFTR_PAGE_RESET = 8'h00;
  localparam logic [7:0] SFTR_FILTER_MASK = 8'h03;
  localparam logic [7:0] SFTR_PAGE_MASK = 8'h01;
  localparam int SFTR_FILT_SYN0_BIT = 0;
  localparam int SFTR_FILT_SYN1_BIT = 1;
  localparam int SFTR_TRIM_FRAC_BITS = 32;
  localparam int SFTR_PHASE_STEPS = 256;
  localparam logic [7:0] SFTR_ZERO_BYTE = 8'h00;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } sftr_req_t;

  // settings handed to the synthesizers
  typedef struct packed {
    logic [31:0] trim;
    logic synth_zero_loop_filter_choice;
    logic synth_one_loop_filter_choice;
    logic [7:0] synth_zero_phase_advance;
  } sftr_cfg_t;
endpackage : sftr_pkg

// ---- rtl/sftr_byte_reg.sv ----
// one byte-wide register with write mask and reset value
// assumes synchronous reset and clock enable from the bank
`timescale 1ns/100ps
module sftr_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hff
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_q
);
  // reserved bits keep their reset value and so read as zero
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_q <= RESET_VAL;
    end else if (i_ce && i_we) begin
      o_q <= (i_wdata & WR_MASK) | (RESET_VAL & ~WR_MASK);
    end
  end
endmodule : sftr_byte_reg

// ---- rtl/sftr_nco_scale.sv ----
// applies the shared centre trim to one nominal frequency word
// assumes the nominal word is steady; result is registered
`timescale 1ns/100ps
module sftr_nco_scale
  import sftr_pkg::*;
#(
  parameter int FW = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic [31:0] i_trim,
  input wire logic [FW-1:0] i_finit,
  output logic [FW-1:0] o_fout
);
  initial begin
    if (FW < 1 || FW > 64) $error("sftr_nco_scale: FW out of range");
  end
  logic signed [FW+32:0] prod;
  logic [FW-1:0] next_fout;
  // fout = finit + finit*trim/2^32, signed trim
  always_comb begin
    prod = $signed({1'b0, i_finit}) * $signed(i_trim);
    next_fout = i_finit + FW'(prod >>> SFTR_TRIM_FRAC_BITS);
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_fout <= '0;
    end else if (i_ce) begin
      o_fout <= next_fout;
    end
  end
endmodule : sftr_nco_scale

// ---- rtl/sftr_regs.sv ----
// synthesizer centre trim, loop filter and phase advance registers
// assumes a byte register port synchronous to i_ref_clk; paging held here
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/100ps
module sftr_regs
  import sftr_pkg::*;
#(
  parameter int N_SYNTH = 4,
  parameter int N_POST = 4,
  parameter int FW = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire sftr_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output sftr_cfg_t o_cfg,
  output logic o_page_select,
  input wire logic [N_SYNTH*FW-1:0] i_finit,
  output logic [N_SYNTH*FW-1:0] o_fout,
  output logic [N_POST*8-1:0] o_post_phase_zero
);
  initial begin
    if (N_SYNTH < 1) $error("sftr_regs: N_SYNTH must be at least one");
    if (N_POST < 1) $error("sftr_regs: N_POST must be at least one");
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [7:0] full_addr;
  logic hit_page, hit_trim, hit_filt, hit_phase;
  logic [1:0] trim_idx;
  always_comb begin
    full_addr = {o_page_select, i_req.addr};
    hit_page = (i_req.addr == SFTR_ADDR_PAGE[6:0]);
    hit_trim = (full_addr >= SFTR_ADDR_TRIM_B0) && (full_addr <= SFTR_ADDR_TRIM_B3);
    hit_filt = (full_addr == SFTR_ADDR_FILTER);
    hit_phase = (full_addr == SFTR_ADDR_PHASE0);
    trim_idx = 2'(full_addr - SFTR_ADDR_TRIM_B0);
  end

  // ---------------------------------------------------------------
  // page, filter and phase bytes
  // ---------------------------------------------------------------
  logic [7:0] page_q, filt_q, phase_q;
  sftr_byte_reg #(.RESET_VAL(SFTR_PAGE_RESET), .WR_MASK(SFTR_PAGE_MASK)) u_page (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_we(i_req.wr && hit_page), .i_wdata(i_req.wdata), .o_q(page_q));
  // reserved filter bits forced low
  sftr_byte_reg #(.RESET_VAL(SFTR_FILTER_RESET), .WR_MASK(SFTR_FILTER_MASK)) u_filt (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_we(i_req.wr && hit_filt), .i_wdata(i_req.wdata), .o_q(filt_q));
  sftr_byte_reg #(.RESET_VAL(SFTR_PHASE_RESET), .WR_MASK(8'hff)) u_phase (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_we(i_req.wr && hit_phase), .i_wdata(i_req.wdata), .o_q(phase_q));
  assign o_page_select = page_q[0];

  // ---------------------------------------------------------------
  // centre trim: staged bytes, committed together
  // ---------------------------------------------------------------
  // staging avoids a torn value reaching the synthesizers mid-update
  logic [31:0] trim_stage;
  logic [31:0] trim_live;
  logic [3:0] trim_written;
  logic [3:0] next_written;
  always_comb begin
    next_written = trim_written;
    if (i_req.wr && hit_trim) begin
      next_written[trim_idx] = 1'b1;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      trim_stage <= SFTR_TRIM_RESET;
    end else if (i_ce && i_req.wr && hit_trim) begin
      trim_stage[trim_idx*8 +: 8] <= i_req.wdata;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      trim_written <= '0;
    end else if (i_ce) begin
      trim_written <= (&next_written) ? '0 : next_written;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      trim_live <= SFTR_TRIM_RESET;
    end else if (i_ce && (&next_written)) begin
      trim_live <= trim_stage;
      trim_live[trim_idx*8 +: 8] <= i_req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // read path: the host reads back the staged trim bytes
  // ---------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = SFTR_ZERO_BYTE;
    if (hit_page) begin
      next_rdata = page_q;
    end else if (hit_trim) begin
      next_rdata = trim_stage[trim_idx*8 +: 8];
    end else if (hit_filt) begin
      next_rdata = filt_q;
    end else if (hit_phase) begin
      next_rdata = phase_q;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_rdata <= SFTR_ZERO_BYTE;
      o_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_rvalid <= i_req.rd;
      if (i_req.rd) begin
        o_rdata <= next_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // settings to the synthesizers
  // ---------------------------------------------------------------
  always_comb begin
    o_cfg.trim = trim_live;
    o_cfg.synth_zero_loop_filter_choice = filt_q[SFTR_FILT_SYN0_BIT];
    o_cfg.synth_one_loop_filter_choice = filt_q[SFTR_FILT_SYN1_BIT];
    o_cfg.synth_zero_phase_advance = phase_q;
  end
  // each post divider of synthesizer zero sees the same advance
  always_comb begin
    for (int p = 0; p < N_POST; p++) begin
      o_post_phase_zero[p*8 +: 8] = phase_q;
    end
  end

  // one shared trim scales every synthesizer's initial frequency
  for (genvar s = 0; s < N_SYNTH; s++) begin : g_nco
    sftr_nco_scale #(.FW(FW)) u_nco (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_trim(trim_live),
      .i_finit(i_finit[s*FW +: FW]),
      .o_fout(o_fout[s*FW +: FW])
    );
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_trim_reset;
    @(posedge i_ref_clk) $past(i_srst) |-> trim_live == SFTR_TRIM_RESET;
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("trim not at reset value");

  property p_trim_hold;
    @(posedge i_ref_clk) disable iff (i_srst)
      !(&next_written) |=> trim_live == $past(trim_live);
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim changed before full write");

  property p_filter_bits;
    @(posedge i_ref_clk) disable iff (i_srst)
      o_cfg.synth_one_loop_filter_choice == filt_q[1] && filt_q[7:2] == 6'h00;
  endproperty
  a_filter_bits: assert property (p_filter_bits) else $error("filter reserved bits set");

  property p_filter_zero;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_ce && i_req.wr && hit_filt |=> o_cfg.synth_zero_loop_filter_choice == $past(i_req.wdata[0]);
  endproperty
  a_filter_zero: assert property (p_filter_zero) else $error("synth zero filter wrong");

  property p_phase;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_ce && i_req.wr && hit_phase |=> o_cfg.synth_zero_phase_advance == $past(i_req.wdata);
  endproperty
  a_phase: assert property (p_phase) else $error("phase advance not stored");

  property p_post_same;
    @(posedge i_ref_clk) disable iff (i_srst)
      o_post_phase_zero[N_POST*8-1 -: 8] == o_cfg.synth_zero_phase_advance;
  endproperty
  a_post_same: assert property (p_post_same) else $error("post divider phase differs");

  property p_trim_out;
    @(posedge i_ref_clk) disable iff (i_srst) o_cfg.trim == trim_live;
  endproperty
  a_trim_out: assert property (p_trim_out) else $error("trim output mismatch");

  property p_nco_zero;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_ce && trim_live == 32'h00000000 && $stable(i_finit) |=> o_fout[FW-1:0] == i_finit[FW-1:0];
  endproperty
  a_nco_zero: assert property (p_nco_zero) else $error("zero trim must not move freq");

  c_trim_commit: cover property (@(posedge i_ref_clk) i_ce && (&next_written));
  c_page_one: cover property (@(posedge i_ref_clk) o_page_select);
  c_read: cover property (@(posedge i_ref_clk) o_rvalid);
endmodule : sftr_regs

// ---- dv/sftr_host.sv ----
// host model that configures the trim bank over its byte register port
// assumes one request per xfer call and a fixed one-cycle read latency
`timescale 1ns/100ps
module sftr_host
  import sftr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output sftr_req_t o_req
);
  initial o_req = '0;
  // --------------------------------------------------
  // one access: request held for one edge, answer taken a half cycle on
  // --------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic v, output logic [7:0] q);
    @(posedge i_ref_clk);
    o_req <= '{wr: w, rd: !w, addr: a[6:0], wdata: d};
    @(posedge i_ref_clk);
    o_req <= '0;
    @(negedge i_ref_clk);
    v = i_rvalid;
    q = i_rdata;
  endtask : xfer
  // page bit written before any in-page access below 0x7f
  task automatic set_page(input logic p);
    logic v;
    logic [7:0] q;
    xfer(1'b1, SFTR_ADDR_PAGE, {7'h00, p}, v, q);
  endtask : set_page
endmodule : sftr_host

// ---- dv/sftr_regs_tb.sv ----
// self-checking bench for the synthesizer trim register bank
// assumes the host model drives the register port; all four synths share one trim
`timescale 1ns/100ps
module sftr_regs_tb
  import sftr_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_ce = 1'b1;
  sftr_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic page;
  sftr_cfg_t cfg;
  logic [127:0] finit = {32'h40000000, 32'h30000000, 32'h20000000, 32'h10000000};
  logic [127:0] fout;
  logic [31:0] post;
  int failures = 0;
  int n_checks = 0;
  initial forever #2.5 i_ref_clk = ~i_ref_clk;
  sftr_regs dut_u (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce), .i_req(req),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_cfg(cfg), .o_page_select(page),
    .i_finit(finit), .o_fout(fout), .o_post_phase_zero(post));
  sftr_host host_u (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic v;
    logic [7:0] q;
    host_u.xfer(1'b0, a, 8'h00, v, q);
    chk("rvalid", 64'h1, {63'h0, v});
    chk(nm, {56'h0, e}, {56'h0, q});
  endtask : rd_chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic v;
    logic [7:0] q;
    host_u.xfer(1'b1, a, d, v, q);
  endtask : wr
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  task automatic t_reset;
    chk("trim", {32'h0, SFTR_TRIM_RESET}, {32'h0, cfg.trim});
    for (int b = 0; b < 4; b++) begin
      rd_chk("trim byte", SFTR_ADDR_TRIM_B0 + b, SFTR_TRIM_RESET[8*b +: 8]);
    end
    rd_chk("filter", SFTR_ADDR_FILTER, SFTR_FILTER_RESET);
    rd_chk("phase", SFTR_ADDR_PHASE0, SFTR_PHASE_RESET);
  endtask : t_reset
  // trim values stay inside five percent of nominal
  task automatic t_trim(input logic [31:0] t);
    logic [31:0] old;
    logic [31:0] f;
    logic signed [63:0] p;
    old = cfg.trim;
    wr(8'h74, t[15:8]);
    wr(8'h76, t[31:24]);
    wr(8'h73, t[7:0]);
    wr(8'h74, t[15:8]);
    chk("trim held", {32'h0, old}, {32'h0, cfg.trim});
    wr(8'h75, t[23:16]);
    repeat (2) @(negedge i_ref_clk);
    chk("trim new", {32'h0, t}, {32'h0, cfg.trim});
    repeat (2) @(negedge i_ref_clk);
    for (int s = 0; s < 4; s++) begin
      f = finit[32*s +: 32];
      p = $signed({32'h0, f}) * $signed({{32{t[31]}}, t});
      chk("fout", {32'h0, f + p[63:32]}, {32'h0, fout[32*s +: 32]});
    end
  endtask : t_trim
  task automatic t_filter;
    wr(SFTR_ADDR_FILTER, 8'hff);
    rd_chk("filter rsvd", SFTR_ADDR_FILTER, 8'h03);
    wr(SFTR_ADDR_FILTER, 8'h01);
    chk("filter0", 64'h1, {63'h0, cfg.synth_zero_loop_filter_choice});
    chk("filter1", 64'h0, {63'h0, cfg.synth_one_loop_filter_choice});
    wr(SFTR_ADDR_FILTER, 8'h02);
    chk("filter1 int", 64'h1, {63'h0, cfg.synth_one_loop_filter_choice});
  endtask : t_filter
  task automatic t_phase;
    wr(SFTR_ADDR_PHASE0, 8'ha5);
    chk("phase", 64'ha5, {56'h0, cfg.synth_zero_phase_advance});
    for (int k = 0; k < 4; k++) begin
      chk("post phase", 64'ha5, {56'h0, post[8*k +: 8]});
    end
  endtask : t_phase
  task automatic t_page;
    wr(SFTR_ADDR_PAGE, 8'hff);
    rd_chk("page", SFTR_ADDR_PAGE, 8'h01);
    chk("page out", 64'h1, {63'h0, page});
    wr(SFTR_ADDR_PHASE0, 8'h3c);
    host_u.set_page(1'b0);
    rd_chk("phase kept", SFTR_ADDR_PHASE0, 8'ha5);
    rd_chk("unmapped", 8'h7e, 8'h00);
  endtask : t_page
  // a phase write while the enable is low must leave the phase register as it was
  task automatic t_freeze;
    @(posedge i_ref_clk);
    i_ce <= 1'b0;
    wr(SFTR_ADDR_PHASE0, 8'h11);
    chk("phase frozen", 64'ha5, {56'h0, cfg.synth_zero_phase_advance});
    @(posedge i_ref_clk);
    i_ce <= 1'b1;
    rd_chk("phase after freeze", SFTR_ADDR_PHASE0, 8'ha5);
  endtask : t_freeze
  // --------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------
  initial begin
    repeat (6) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    @(negedge i_ref_clk);
    t_reset();
    t_trim(32'h0539782a);
    t_trim(32'hfafafafb);
    t_filter();
    t_phase();
    t_page();
    t_freeze();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    failures++;
    report_and_stop();
  end
endmodule : sftr_regs_tb
